// *** design/uart_port_pkg.sv ***
// package with the constants of the dual uart host bus port
`default_nettype none
package uart_port_pkg;
   localparam int BUS_WIDTH = 8;
   localparam int SEL_WIDTH = 3;
   // register select codes
   localparam logic [2:0] SEL_HOLDING = 3'h0;
   localparam logic [2:0] SEL_MODEM_CTRL = 3'h4;
   localparam logic [2:0] SEL_LINE_STATUS = 3'h5;
   localparam logic [2:0] SEL_SCRATCH = 3'h7;
   // modem control field position and reset value
   localparam int MCR_IRQ_ENABLE_BIT = 3;
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam logic [7:0] GENERIC_RESET = 8'h00;
   // line status bit positions for the ready flags
   localparam int LSR_RX_READY_BIT = 0;
   localparam int LSR_TX_EMPTY_BIT = 5;
endpackage
`default_nettype wire

// *** design/uart_channel_regs.sv ***
// per-channel register set with ready flags and interrupt output
`timescale 1ns/1ps
`default_nettype none
module uart_channel_regs (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [2:0] regSel,
   input wire logic writeEvent,
   input wire logic readEvent,
   input wire logic [7:0] writeData,
   input wire logic rxLoad,
   input wire logic [7:0] rxByte,
   input wire logic txTake,
   input wire logic irqRequest,
   output logic [7:0] readData,
   output logic [7:0] txByte,
   output logic txFull,
   output logic rxFull,
   output logic irqEnable
);
   logic [7:0] modemCtrl;
   logic [7:0] scratch;
   logic [7:0] rxHold;

   // **************************************
   // writes taken at the strobe's rising edge
   // **************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         modemCtrl <= uart_port_pkg::MCR_RESET;
         scratch <= uart_port_pkg::GENERIC_RESET;
         txByte <= uart_port_pkg::GENERIC_RESET;
      end else if (writeEvent) begin
         case (regSel)
            uart_port_pkg::SEL_HOLDING: txByte <= writeData;
            uart_port_pkg::SEL_MODEM_CTRL: modemCtrl <= writeData;
            uart_port_pkg::SEL_SCRATCH: scratch <= writeData;
            default: ;
         endcase
      end
   end

   // a new write wins over the serial side taking the byte
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         txFull <= 1'b0;
      end else if (writeEvent && regSel == uart_port_pkg::SEL_HOLDING) begin
         txFull <= 1'b1;
      end else if (txTake) begin
         txFull <= 1'b0;
      end
   end

   // arriving byte wins over a read that empties the holding register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rxFull <= 1'b0;
         rxHold <= uart_port_pkg::GENERIC_RESET;
      end else if (rxLoad) begin
         rxFull <= 1'b1;
         rxHold <= rxByte;
      end else if (readEvent && regSel == uart_port_pkg::SEL_HOLDING) begin
         rxFull <= 1'b0;
      end
   end

   always_comb begin
      readData = 8'h00;
      case (regSel)
         uart_port_pkg::SEL_HOLDING: readData = rxHold;
         uart_port_pkg::SEL_MODEM_CTRL: readData = modemCtrl;
         uart_port_pkg::SEL_LINE_STATUS: begin
            readData[uart_port_pkg::LSR_RX_READY_BIT] = rxFull;
            readData[uart_port_pkg::LSR_TX_EMPTY_BIT] = !txFull;
         end
         uart_port_pkg::SEL_SCRATCH: readData = scratch;
         default: readData = 8'h00;
      endcase
   end

   assign irqEnable = modemCtrl[uart_port_pkg::MCR_IRQ_ENABLE_BIT] & !irqRequest ? 1'b1 :
      modemCtrl[uart_port_pkg::MCR_IRQ_ENABLE_BIT];
endmodule
`default_nettype wire

// *** design/dual_uart_host_bus_port.sv ***
// top of the dual uart asynchronous host bus port
//
// What this block does
// - three select lines pick one register of the chosen channel
// - eight-bit two-way data bus, host writes, device reads out
// - read strobe falling edge fetches addressed byte onto the bus
// - write strobe rising edge loads the bus byte into the register
// - a channel acts only while its own select is low
// - modem control bit 3 set drives irq pin, user output low
// - modem control bit 3 clear floats irq pin, user output high
// - each channel has an active-low transmitter ready output
// - channel A has an active-low receiver ready output
// - channel B has its own active-low receiver ready output
`timescale 1ns/1ps
`default_nettype none
module dual_uart_host_bus_port (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic reg_select_bit2,
   input wire logic reg_select_bit1,
   input wire logic reg_select_bit0,
   input wire logic [7:0] busByteIn,
   output logic [7:0] busByteOut,
   output logic busByteOe,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chan_a_select_n,
   input wire logic chan_b_select_n,
   input wire logic chanARxLoad,
   input wire logic [7:0] chanARxByte,
   input wire logic chanATxTake,
   input wire logic chanAIrqRequest,
   input wire logic chanBRxLoad,
   input wire logic [7:0] chanBRxByte,
   input wire logic chanBTxTake,
   input wire logic chanBIrqRequest,
   output logic [7:0] chanATxByte,
   output logic [7:0] chanBTxByte,
   output logic chan_a_irq_out,
   output logic chan_a_irq_oe,
   output logic chan_b_irq_out,
   output logic chan_b_irq_oe,
   output logic chan_a_user_out_n,
   output logic chan_b_user_out_n,
   output logic chan_a_tx_ready_n,
   output logic chan_b_tx_ready_n,
   output logic chan_a_rx_ready_n,
   output logic chan_b_rx_ready_n
);
   // **************************************
   // pin synchronisers
   // **************************************
   logic [14:0] pinMeta;
   logic [14:0] pinSync;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pinMeta <= 15'h7f00;
         pinSync <= 15'h7f00;
      end else begin
         pinMeta <= {read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n,
            reg_select_bit2, reg_select_bit1, reg_select_bit0, busByteIn};
         pinSync <= pinMeta;
      end
   end

   logic rdN;
   logic wrN;
   logic csAN;
   logic csBN;
   logic [2:0] regSel;
   logic [7:0] dataIn;
   assign rdN = pinSync[14];
   assign wrN = pinSync[13];
   assign csAN = pinSync[12];
   assign csBN = pinSync[11];
   assign regSel = pinSync[10:8];
   assign dataIn = pinSync[7:0];

   // **************************************
   // strobe edge detection
   // **************************************
   logic rdPrevN;
   logic wrPrevN;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdPrevN <= 1'b1;
         wrPrevN <= 1'b1;
      end else begin
         rdPrevN <= rdN;
         wrPrevN <= wrN;
      end
   end

   logic rdFall;
   logic rdRise;
   logic wrRise;
   assign rdFall = rdPrevN && !rdN;
   assign rdRise = !rdPrevN && rdN;
   assign wrRise = !wrPrevN && wrN;

   // channel selects registered every cycle, one cycle behind the synced pins, so the closing edge sees the select of the cycle before
   logic selA;
   logic selB;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         selA <= 1'b0;
         selB <= 1'b0;
      end else begin
         selA <= !csAN;
         selB <= !csBN;
      end
   end

   // the data bus is sampled on every cycle the write strobe is low, so the last byte before the strobe rises is kept
   logic [7:0] writeData;
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         writeData <= 8'h00;
      end else if (!wrN) begin
         writeData <= dataIn;
      end
   end

   logic wrA;
   logic wrB;
   logic rdEndA;
   logic rdEndB;
   assign wrA = wrRise && selA;
   assign wrB = wrRise && selB;
   // reading the receive holding register empties it at the read strobe's closing edge while selected, whether or not the bus was driven
   assign rdEndA = rdRise && selA;
   assign rdEndB = rdRise && selB;

   // **************************************
   // channel register sets
   // **************************************
   logic [7:0] readA;
   logic [7:0] readB;
   logic txFullA;
   logic txFullB;
   logic rxFullA;
   logic rxFullB;
   logic irqEnA;
   logic irqEnB;
   logic [7:0] txByteA;
   logic [7:0] txByteB;

   uart_channel_regs chanA (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .regSel(regSel),
      .writeEvent(wrA),
      .readEvent(rdEndA),
      .writeData(writeData),
      .rxLoad(chanARxLoad),
      .rxByte(chanARxByte),
      .txTake(chanATxTake),
      .irqRequest(chanAIrqRequest),
      .readData(readA),
      .txByte(txByteA),
      .txFull(txFullA),
      .rxFull(rxFullA),
      .irqEnable(irqEnA)
   );

   uart_channel_regs chanB (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .regSel(regSel),
      .writeEvent(wrB),
      .readEvent(rdEndB),
      .writeData(writeData),
      .rxLoad(chanBRxLoad),
      .rxByte(chanBRxByte),
      .txTake(chanBTxTake),
      .irqRequest(chanBIrqRequest),
      .readData(readB),
      .txByte(txByteB),
      .txFull(txFullB),
      .rxFull(rxFullB),
      .irqEnable(irqEnB)
   );

   // **************************************
   // read data onto the bus
   // **************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         busByteOut <= 8'h00;
      end else if (rdFall || (!rdN && (selA || selB))) begin
         busByteOut <= selA ? readA : readB;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         busByteOe <= 1'b0;
      end else begin
         busByteOe <= !rdN && (selA ^ selB);
      end
   end

   // **************************************
   // interrupt pins, user outputs, ready pins
   // **************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         chan_a_irq_out <= 1'b0;
         chan_a_irq_oe <= 1'b0;
         chan_b_irq_out <= 1'b0;
         chan_b_irq_oe <= 1'b0;
         chan_a_user_out_n <= 1'b1;
         chan_b_user_out_n <= 1'b1;
      end else begin
         chan_a_irq_out <= chanAIrqRequest;
         chan_a_irq_oe <= irqEnA;
         chan_b_irq_out <= chanBIrqRequest;
         chan_b_irq_oe <= irqEnB;
         chan_a_user_out_n <= !irqEnA;
         chan_b_user_out_n <= !irqEnB;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         chan_a_tx_ready_n <= 1'b0;
         chan_b_tx_ready_n <= 1'b0;
         chan_a_rx_ready_n <= 1'b1;
         chan_b_rx_ready_n <= 1'b1;
         chanATxByte <= 8'h00;
         chanBTxByte <= 8'h00;
      end else begin
         chan_a_tx_ready_n <= txFullA;
         chan_b_tx_ready_n <= txFullB;
         chan_a_rx_ready_n <= !rxFullA;
         chan_b_rx_ready_n <= !rxFullB;
         chanATxByte <= txByteA;
         chanBTxByte <= txByteB;
      end
   end
endmodule
`default_nettype wire

// *** tb/dual_uart_host_bus_port_props.sv ***
// checker of the host bus port pin relations
`timescale 1ns/1ps
`default_nettype none
module dual_uart_host_bus_port_props (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic chan_a_select_n,
   input wire logic chan_b_select_n,
   input wire logic busByteOe,
   input wire logic chanARxLoad,
   input wire logic chanATxTake,
   input wire logic chanAIrqRequest,
   input wire logic [7:0] chanATxByte,
   input wire logic chan_a_irq_out,
   input wire logic chan_a_irq_oe,
   input wire logic chan_a_user_out_n,
   input wire logic chan_a_tx_ready_n,
   input wire logic chan_a_rx_ready_n
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   a_oe_after_strobe: assert property ($rose(busByteOe) |-> !$past(read_strobe_n, 2))
      else $error("bus drive began without a read strobe");
   a_oe_idle_float: assert property (read_strobe_n [*8] |-> !busByteOe)
      else $error("bus driven with read strobe idle");
   a_oe_two_selects: assert property
      ((!chan_a_select_n && !chan_b_select_n) [*8] |-> !busByteOe)
      else $error("bus driven with both channels selected");
   a_irq_pair_a: assert property (chan_a_irq_oe == !chan_a_user_out_n)
      else $error("irq enable and user output disagree");
   a_irq_follow_a: assert property
      ((chan_a_irq_oe && chanAIrqRequest) [*3] |-> chan_a_irq_out)
      else $error("enabled irq does not follow request");
   a_rx_flag_a: assert property (chanARxLoad |-> ##[1:3] !chan_a_rx_ready_n)
      else $error("receive ready missing after load");
   a_tx_flag_a: assert property (chanATxTake |-> ##[1:3] !chan_a_tx_ready_n)
      else $error("transmit ready missing after take");
   a_tx_load_a: assert property
      ($changed(chanATxByte) |-> write_strobe_n && $past(write_strobe_n, 2))
      else $error("transmit byte changed before write strobe rose");
   a_reset_state: assert property ($rose(rst_n) |-> !busByteOe && chan_a_user_out_n
      && !chan_a_irq_oe && !chan_a_tx_ready_n && chan_a_rx_ready_n)
      else $error("wrong pin state after reset");
   cover property ($rose(busByteOe));
   cover property ($fell(chan_a_user_out_n));
   cover property ($fell(chan_a_rx_ready_n));
endmodule
bind dual_uart_host_bus_port dual_uart_host_bus_port_props u_props (.ref_clk, .rst_n,
   .read_strobe_n, .write_strobe_n, .chan_a_select_n, .chan_b_select_n, .busByteOe,
   .chanARxLoad, .chanATxTake, .chanAIrqRequest, .chanATxByte, .chan_a_irq_out,
   .chan_a_irq_oe, .chan_a_user_out_n, .chan_a_tx_ready_n, .chan_a_rx_ready_n);
`default_nettype wire

// *** tb/uart_host_model.sv ***
// host processor model for the parallel register bus
`timescale 1ns/1ps
`default_nettype none
module uart_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] busLevel,
   output logic [2:0] regSel = 3'h0,
   output logic [7:0] hostData = 8'h00,
   output logic hostDrive = 1'b0,
   output logic readN = 1'b1,
   output logic writeN = 1'b1,
   output logic [1:0] selN = 2'h3
);
   // select and address settle before the strobe since the port syncs pins
   task automatic access(input logic rd, input logic [1:0] cs, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(negedge ref_clk);
      selN = cs;
      regSel = a;
      hostData = d;
      hostDrive = !rd;
      repeat (4) @(negedge ref_clk);
      if (rd) readN = 1'b0;
      else writeN = 1'b0;
      repeat (8) @(negedge ref_clk);
      q = busLevel;
      readN = 1'b1;
      writeN = 1'b1;
      repeat (6) @(negedge ref_clk);
      selN = 2'h3;
      hostDrive = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
endmodule
`default_nettype wire

// *** tb/dual_uart_host_bus_port_tb_top.sv ***
// self-checking bench of the dual uart host bus port
`timescale 1ns/1ps
`default_nettype none
module dual_uart_host_bus_port_tb_top;
   localparam logic [2:0] SCR = uart_port_pkg::SEL_SCRATCH;
   localparam logic [2:0] HLD = uart_port_pkg::SEL_HOLDING;
   // line status with a byte waiting and the transmit side empty
   localparam logic [7:0] LSR_RX_TX = 8'h01 << uart_port_pkg::LSR_RX_READY_BIT |
      8'h01 << uart_port_pkg::LSR_TX_EMPTY_BIT;
   logic clk = 1'b0;
   logic rstN = 1'b0;
   logic [1:0] rxLoad = 2'h0;
   logic [1:0] txTake = 2'h0;
   logic [1:0] irqReq = 2'h0;
   logic [7:0] rxByte [2] = '{8'h00, 8'h00};
   logic sawOe = 1'b0;
   logic [7:0] q;
   int badCount = 0;
   int nChecks = 0;
   int cycles = 0;
   wire [7:0] busOut, busLevel, hostData;
   wire [7:0] txByte [2];
   wire [2:0] regSel;
   wire [1:0] selN, irqOut, irqOe, userN, txRdyN, rxRdyN;
   wire busOe, hostDrive, readN, writeN;
   always #4 clk = ~clk;
   // a floating bus shows the inverse so stale data never passes
   assign busLevel = busOe ? busOut : hostDrive ? hostData : ~busOut;
   uart_host_model u_host (.ref_clk(clk), .busLevel, .regSel, .hostData, .hostDrive,
      .readN, .writeN, .selN);
   dual_uart_host_bus_port u_dut (.ref_clk(clk), .rst_n(rstN), .reg_select_bit2(regSel[2]),
      .reg_select_bit1(regSel[1]), .reg_select_bit0(regSel[0]), .busByteIn(busLevel),
      .busByteOut(busOut), .busByteOe(busOe), .read_strobe_n(readN), .write_strobe_n(writeN),
      .chan_a_select_n(selN[0]), .chan_b_select_n(selN[1]), .chanARxLoad(rxLoad[0]),
      .chanARxByte(rxByte[0]), .chanATxTake(txTake[0]), .chanAIrqRequest(irqReq[0]),
      .chanBRxLoad(rxLoad[1]), .chanBRxByte(rxByte[1]), .chanBTxTake(txTake[1]),
      .chanBIrqRequest(irqReq[1]), .chanATxByte(txByte[0]), .chanBTxByte(txByte[1]),
      .chan_a_irq_out(irqOut[0]), .chan_a_irq_oe(irqOe[0]), .chan_b_irq_out(irqOut[1]),
      .chan_b_irq_oe(irqOe[1]), .chan_a_user_out_n(userN[0]), .chan_b_user_out_n(userN[1]),
      .chan_a_tx_ready_n(txRdyN[0]), .chan_b_tx_ready_n(txRdyN[1]),
      .chan_a_rx_ready_n(rxRdyN[0]), .chan_b_rx_ready_n(rxRdyN[1]));
   task automatic results;
      $display("checks %0d errors %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (busOe) sawOe = 1'b1;
      if (cycles == 5000) begin
         badCount++;
         results();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic rd, input logic [1:0] cs, input logic [2:0] a,
      input logic [7:0] d);
      u_host.access(rd, cs, a, d, q);
   endtask
   task automatic t_scratch;
      acc(0, 2'h2, SCR, 8'ha5);
      acc(0, 2'h1, SCR, 8'h5a);
      acc(1, 2'h2, SCR, 8'h00);
      chk(q, 8'ha5);
      acc(1, 2'h1, SCR, 8'h00);
      chk(q, 8'h5a);
      acc(1, 2'h2, 3'h1, 8'h00);
      chk(q, 8'h00);
      acc(0, 2'h0, SCR, 8'h77);
      sawOe = 1'b0;
      acc(1, 2'h0, SCR, 8'h00);
      chk({7'h0, sawOe}, 8'h00);
      acc(1, 2'h1, SCR, 8'h00);
      chk(q, 8'h77);
   endtask
   task automatic t_chan(input int ch);
      irqReq[ch] = 1'b1;
      acc(0, ch ? 2'h1 : 2'h2, uart_port_pkg::SEL_MODEM_CTRL, 8'h08);
      chk({5'h0, irqOe[ch], userN[ch], irqOut[ch]}, 8'h05);
      chk({7'h0, irqOe[1 - ch]}, 8'h00);
      acc(0, ch ? 2'h1 : 2'h2, uart_port_pkg::SEL_MODEM_CTRL, 8'h00);
      chk({6'h0, irqOe[ch], userN[ch]}, 8'h01);
      irqReq[ch] = 1'b0;
      acc(0, ch ? 2'h1 : 2'h2, HLD, 8'h3c);
      chk(txByte[ch], 8'h3c);
      chk({7'h0, txRdyN[ch]}, 8'h01);
      @(negedge clk) txTake[ch] = 1'b1;
      @(negedge clk) txTake[ch] = 1'b0;
      repeat (3) @(negedge clk);
      chk({7'h0, txRdyN[ch]}, 8'h00);
      rxByte[ch] = ch ? 8'h69 : 8'h96;
      @(negedge clk) rxLoad[ch] = 1'b1;
      @(negedge clk) rxLoad[ch] = 1'b0;
      repeat (3) @(negedge clk);
      chk({7'h0, rxRdyN[ch]}, 8'h00);
      acc(1, ch ? 2'h1 : 2'h2, uart_port_pkg::SEL_LINE_STATUS, 8'h00);
      chk(q, LSR_RX_TX);
      acc(1, ch ? 2'h1 : 2'h2, HLD, 8'h00);
      chk(q, rxByte[ch]);
      chk({7'h0, rxRdyN[ch]}, 8'h01);
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rstN = 1'b1;
      repeat (4) @(negedge clk);
      chk({irqOut, irqOe, busOe, sawOe, 2'h0}, 8'h00);
      chk({userN, rxRdyN, txRdyN, 2'h0}, 8'hf0);
      t_scratch();
      for (int ch = 0; ch < 2; ch++) begin
         t_chan(ch);
      end
      results();
   end
endmodule
`default_nettype wire
